// >>> rtl/sdcs_cfg_regs.sv
// status, class code / revision and latency / line size configuration registers
//
// Function
// - devsel timing reads medium, target uses medium
// - parity flag needs perr, mastership, response enable
// - back-to-back capable bit reads zero
// - user feature bit hardwired zero
// - high speed capable bit reads zero
// - capability list bit always reads one
// - intx active: pending set, disable clear
// - disable masks output only, pending keeps tracking
// - pending set only by enabled conditions
// - low reserved status bits read zero
// - base class byte reads system peripheral
// - subclass byte reads sd host value
// - programming interface follows dma enable bit
// - low byte gives fixed silicon revision
// - latency and line size writable, reset zero
// - class code register entirely read-only
// - write one clears status flag, zero keeps
// - latency counter ends burst after grant loss
`timescale 1ns/1ps
module sdcs_cfg_regs (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // configuration access port
  input  wire logic                           cfg_req,
  input  wire logic                           cfg_we,
  input  wire logic [7:0]                     cfg_addr,
  input  wire logic [3:0]                     cfg_be,
  input  wire logic [31:0]                    cfg_wdata,
  output logic                                cfg_ack,
  output logic [31:0]                         cfg_rdata,
  // command and general control bits held elsewhere
  input  wire logic                           cmd_int_disable,
  input  wire logic                           parity_error_response_enable,
  input  wire logic                           dma_enable,
  // pci pins sampled from outside this clock
  input  wire logic                           perr_n_pin,
  input  wire logic                           gnt_n_pin,
  // initiator engine
  input  wire logic                           master_data_phase,
  input  wire logic                           frame_start,
  input  wire logic                           xfer_active,
  input  wire logic                           pclk_tick,
  output logic                                lat_expired,
  output logic                                lat_end_request,
  // error events, one-cycle pulses, bit order 15..11
  input  wire logic [sdcs_pkg::ST_ERR_N-1:0]  err_event,
  // function interrupt sources
  input  wire logic [sdcs_pkg::INT_SRC_N-1:0] int_cond,
  input  wire logic [sdcs_pkg::INT_SRC_N-1:0] int_signal_en,
  // intx open-drain pin
  output logic                                intx_o,
  output logic                                intx_oe,
  // values for the target engine and the bus master
  output logic [1:0]                          devsel_timing,
  output logic [7:0]                          latency_value,
  output logic [7:0]                          system_line_size
);

  // ****************************************************************
  // declarations
  // ****************************************************************

  // pin synchronisers
  logic        perr_n_s1_q;
  logic        perr_n_s2_q;
  logic        gnt_n_s1_q;
  logic        gnt_n_s2_q;

  // master phase delayed to line up with the synchronised perr
  logic [1:0]  mdp_dly_q;
  logic [1:0]  mdp_dly_d;

  // status state
  logic [sdcs_pkg::ST_ERR_N-1:0] err_q;
  logic [sdcs_pkg::ST_ERR_N-1:0] err_d;
  logic        mdp_flag_q;
  logic        mdp_flag_d;
  logic        int_pend_q;
  logic        int_pend_d;

  // latency / line size register
  logic [15:0] lat_line_q;
  logic [15:0] lat_line_d;

  // access decode
  logic        wr_status;
  logic        wr_lat;
  logic [15:0] status_clr;
  logic [15:0] status_word;
  logic [31:0] class_word;
  logic [7:0]  programming_interface_byte_byte;
  logic        mdp_set;

  // read answer
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ack_q;
  logic        ack_d;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************

  // two flops before anything looks at a pin from the pci clock;
  // both reset to the idle high level so no false error follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      perr_n_s1_q <= 1'b1;
      perr_n_s2_q <= 1'b1;
    end else begin
      perr_n_s1_q <= perr_n_pin;
      perr_n_s2_q <= perr_n_s1_q;
    end
  end

  // grant reads as removed just after reset; harmless, the timer is idle
  always_ff @(posedge clk) begin
    if (rst) begin
      gnt_n_s1_q <= 1'b1;
      gnt_n_s2_q <= 1'b1;
    end else begin
      gnt_n_s1_q <= gnt_n_pin;
      gnt_n_s2_q <= gnt_n_s1_q;
    end
  end

  // ****************************************************************
  // access decode
  // ****************************************************************

  // status lives in the upper half of the command/status dword
  assign wr_status = cfg_req && cfg_we && (cfg_addr == sdcs_pkg::OFF_CMD_STATUS);
  assign wr_lat    = cfg_req && cfg_we && (cfg_addr == sdcs_pkg::OFF_LAT_LINE);

  // per-byte write-one-to-clear mask over the status half;
  // a zero bit or a disabled lane leaves its flag alone
  always_comb begin
    status_clr = 16'h0000;
    if (wr_status && cfg_be[3]) begin
      status_clr[15:8] = cfg_wdata[31:24];
    end
    if (wr_status && cfg_be[2]) begin
      status_clr[7:0] = cfg_wdata[23:16];
    end
  end

  // ****************************************************************
  // master data parity flag
  // ****************************************************************

  // delay mastership by the synchroniser depth so both refer to one phase
  always_comb begin
    mdp_dly_d = {mdp_dly_q[0], master_data_phase};
  end

  // cleared on reset so no stale mastership meets the first perr
  always_ff @(posedge clk) begin
    if (rst) begin
      mdp_dly_q <= 2'h0;
    end else begin
      mdp_dly_q <= mdp_dly_d;
    end
  end

  // all three conditions must hold at once
  assign mdp_set = !perr_n_s2_q && mdp_dly_q[1] && parity_error_response_enable;

  // ****************************************************************
  // status next state
  // ****************************************************************

  // set wins over a clear arriving in the same cycle
  always_comb begin
    mdp_flag_d = mdp_flag_q;
    if (status_clr[sdcs_pkg::ST_MDP]) begin
      mdp_flag_d = 1'b0;
    end
    if (mdp_set) begin
      mdp_flag_d = 1'b1;
    end
    // pending follows only the enabled sources; the disable bit plays no part
    int_pend_d = |(int_cond & int_signal_en);
  end

  // one clearable error flag per bit, same set-over-clear order
  for (genvar i = 0; i < sdcs_pkg::ST_ERR_N; i++) begin : g_err
    always_comb begin
      err_d[i] = err_q[i];
      if (status_clr[sdcs_pkg::ST_ERR_LSB + i]) begin
        err_d[i] = 1'b0;
      end
      if (err_event[i]) begin
        err_d[i] = 1'b1;
      end
    end
  end

  // ****************************************************************
  // latency / line size next state
  // ****************************************************************

  // both bytes writable with their own lane
  always_comb begin
    lat_line_d = lat_line_q;
    if (wr_lat && cfg_be[0]) begin
      lat_line_d[7:0] = cfg_wdata[7:0];
    end
    if (wr_lat && cfg_be[1]) begin
      lat_line_d[15:8] = cfg_wdata[15:8];
    end
  end

  // firmware programs both bytes after reset; zero until then
  always_ff @(posedge clk) begin
    if (rst) begin
      lat_line_q <= sdcs_pkg::LAT_LINE_RESET;
    end else begin
      lat_line_q <= lat_line_d;
    end
  end

  // ****************************************************************
  // state registers
  // ****************************************************************

  // status flags; a reset clears every error and the pending bit
  always_ff @(posedge clk) begin
    if (rst) begin
      mdp_flag_q <= 1'b0;
      int_pend_q <= 1'b0;
      err_q      <= sdcs_pkg::ERR_RESET;
    end else begin
      mdp_flag_q <= mdp_flag_d;
      int_pend_q <= int_pend_d;
      err_q      <= err_d;
    end
  end

  // ****************************************************************
  // read values
  // ****************************************************************

  // fixed bits come from constants, so a write can never reach them
  always_comb begin
    status_word = 16'h0000;
    status_word[sdcs_pkg::ST_DEVSEL_LSB +: 2] = sdcs_pkg::DEVSEL_MEDIUM;
    status_word[sdcs_pkg::ST_MDP]             = mdp_flag_q;
    status_word[sdcs_pkg::ST_B2B_CAP]         = sdcs_pkg::B2B_CAP_VAL;
    status_word[sdcs_pkg::ST_USER_FEAT]       = sdcs_pkg::USER_FEAT_VAL;
    status_word[sdcs_pkg::ST_HIGH_SPEED]      = sdcs_pkg::HIGH_SPEED_VAL;
    status_word[sdcs_pkg::ST_CAP_LIST]        = sdcs_pkg::CAP_LIST_VAL;
    status_word[sdcs_pkg::ST_INT_PEND]        = int_pend_q;
    status_word[sdcs_pkg::ST_ERR_LSB +: sdcs_pkg::ST_ERR_N] = err_q;
  end

  // interface byte tracks the dma bit with no register in between
  assign programming_interface_byte_byte = dma_enable ? sdcs_pkg::PROGRAMMING_INTERFACE_BYTE_DMA : sdcs_pkg::PROGRAMMING_INTERFACE_BYTE_NO_DMA;

  // class dword has no storage at all, only constants and the dma bit
  assign class_word = {sdcs_pkg::BASE_CLASS_VAL,
                       sdcs_pkg::SUB_CLASS_VAL,
                       programming_interface_byte_byte,
                       sdcs_pkg::SILICON_REV_VAL};

  // ****************************************************************
  // read answer
  // ****************************************************************

  // answer one cycle after the request; unmapped dwords read zero
  // writes answer too, with zero data, so the host never waits on them
  always_comb begin
    ack_d   = cfg_req;
    rdata_d = rdata_q;
    if (cfg_req) begin
      rdata_d = 32'h0000_0000;
      if (!cfg_we) begin
        unique case (cfg_addr)
          sdcs_pkg::OFF_CMD_STATUS: begin
            rdata_d[sdcs_pkg::ST_HALF_LSB +: 16] = status_word;
          end
          sdcs_pkg::OFF_CLASS_REV: begin
            rdata_d = class_word;
          end
          sdcs_pkg::OFF_LAT_LINE: begin
            rdata_d[15:0] = lat_line_q;
          end
          default: begin
            rdata_d = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // writes to the class dword and to fixed status bits decode to nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_ack   = ack_q;
  assign cfg_rdata = rdata_q;

  // ****************************************************************
  // intx pin
  // ****************************************************************

  // open drain: only ever pulls low, enable carries the assertion
  assign intx_o  = 1'b0;
  assign intx_oe = int_pend_q && !cmd_int_disable;

  // ****************************************************************
  // values for other engines
  // ****************************************************************

  // a latency of zero expires at once: bursts end whenever grant goes
  // the target engine claims cycles with this decode speed
  assign devsel_timing    = sdcs_pkg::DEVSEL_MEDIUM;
  assign latency_value    = lat_line_q[15:8];
  assign system_line_size = lat_line_q[7:0];

  // ****************************************************************
  // latency timer
  // ****************************************************************

  sdcs_lat_timer u_lat_timer (
    .clk             (clk),
    .rst             (rst),
    .frame_start     (frame_start),
    .xfer_active     (xfer_active),
    .pclk_tick       (pclk_tick),
    .gnt_n_sync      (gnt_n_s2_q),
    .latency_value   (latency_value),
    .lat_expired     (lat_expired),
    .lat_end_request (lat_end_request)
  );

endmodule

// >>> rtl/sdcs_pkg.sv
// constants for the sd host configuration status, class code and latency registers
package sdcs_pkg;

  // ****************************************************************
  // configuration offsets (byte address of each dword)
  // ****************************************************************
  localparam logic [7:0] OFF_CMD_STATUS = 8'h04; // status is the upper half
  localparam logic [7:0] OFF_CLASS_REV  = 8'h08;
  localparam logic [7:0] OFF_LAT_LINE   = 8'h0c;

  // ****************************************************************
  // status field positions (within the 16-bit status half)
  // ****************************************************************
  localparam int ST_INT_PEND    = 3;
  localparam int ST_CAP_LIST    = 4;
  localparam int ST_HIGH_SPEED  = 5;
  localparam int ST_USER_FEAT   = 6;
  localparam int ST_B2B_CAP     = 7;
  localparam int ST_MDP         = 8;
  localparam int ST_DEVSEL_LSB  = 9;
  localparam int ST_ERR_LSB     = 11;
  localparam int ST_ERR_N       = 5;  // bits 15..11, all write-one-to-clear
  localparam int ST_HALF_LSB    = 16; // status sits in bits 31..16 of the dword

  // ****************************************************************
  // fixed field values
  // ****************************************************************
  localparam logic [1:0] DEVSEL_MEDIUM   = 2'h1;
  localparam logic       B2B_CAP_VAL     = 1'h0;
  localparam logic       USER_FEAT_VAL   = 1'h0;
  localparam logic       HIGH_SPEED_VAL  = 1'h0;
  localparam logic       CAP_LIST_VAL    = 1'h1;
  localparam logic [7:0] BASE_CLASS_VAL  = 8'h08;
  localparam logic [7:0] SUB_CLASS_VAL   = 8'h05;
  localparam logic [7:0] PROGRAMMING_INTERFACE_BYTE_DMA       = 8'h01;
  localparam logic [7:0] PROGRAMMING_INTERFACE_BYTE_NO_DMA    = 8'h00;
  localparam logic [7:0] SILICON_REV_VAL = 8'h5a; // arbitrary value

  // ****************************************************************
  // reset values and widths
  // ****************************************************************
  localparam logic [15:0] LAT_LINE_RESET = 16'h0000;
  localparam logic [7:0]  LAT_CNT_RESET  = 8'h00;
  localparam logic [4:0]  ERR_RESET      = 5'h00;
  localparam int          INT_SRC_N      = 4;

endpackage

// >>> rtl/sdcs_lat_timer.sv
// master latency timer: counts pci clocks from frame and requests the end of a burst
`timescale 1ns/1ps
module sdcs_lat_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // initiator activity
  input  wire logic       frame_start,
  input  wire logic       xfer_active,
  input  wire logic       pclk_tick,
  input  wire logic       gnt_n_sync,
  // programmed limit
  input  wire logic [7:0] latency_value,
  // results
  output logic            lat_expired,
  output logic            lat_end_request
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       run_q;
  logic       run_d;

  // ****************************************************************
  // counter
  // ****************************************************************

  // restart at zero on our own frame, count pci clocks, saturate
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (frame_start) begin
      cnt_d = sdcs_pkg::LAT_CNT_RESET;
      run_d = 1'b1;
    end else if (!xfer_active) begin
      run_d = 1'b0;
    end else if (run_q && pclk_tick && (cnt_q != 8'hff)) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= sdcs_pkg::LAT_CNT_RESET;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  // expiry only ends the burst once the arbiter has taken the grant away
  assign lat_expired     = run_q && (cnt_q >= latency_value);
  assign lat_end_request = lat_expired && gnt_n_sync && xfer_active;

endmodule

// >>> tb/sdcs_cfg_regs_sva.sv
// assertion checker for the configuration register block
`timescale 1ns/1ps
module sdcs_cfg_regs_sva (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           rst,
  // configuration port
  input wire logic                           cfg_req,
  input wire logic                           cfg_we,
  input wire logic [7:0]                     cfg_addr,
  input wire logic [3:0]                     cfg_be,
  input wire logic [31:0]                    cfg_wdata,
  input wire logic [31:0]                    cfg_rdata,
  // interrupt path
  input wire logic                           cmd_int_disable,
  input wire logic                           dma_enable,
  input wire logic [sdcs_pkg::INT_SRC_N-1:0] int_cond,
  input wire logic [sdcs_pkg::INT_SRC_N-1:0] int_signal_en,
  input wire logic                           intx_o,
  input wire logic                           intx_oe,
  // timing outputs
  input wire logic [1:0]                     devsel_timing,
  input wire logic [7:0]                     latency_value,
  input wire logic [7:0]                     system_line_size,
  input wire logic                           lat_expired,
  input wire logic                           lat_end_request,
  input wire logic                           xfer_active,
  input wire logic                           frame_start
);
  // ********
  // properties
  // ********
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_devsel_medium: assert property (devsel_timing == 2'h1)
    else $error("devsel timing not medium");
  a_intx_masked: assert property (cmd_int_disable |-> !intx_oe && !intx_o)
    else $error("intx driven while disabled");
  // pending lags the enabled sources by one cycle
  a_pend_raises: assert property ((int_cond & int_signal_en) != '0 |=> cmd_int_disable || intx_oe)
    else $error("intx not driven for enabled source");
  a_pend_quiet: assert property ((int_cond & int_signal_en) == '0 |=> !intx_oe)
    else $error("intx driven without enabled source");
  a_class_read: assert property (cfg_req && !cfg_we && cfg_addr == 8'h08 |=>
    cfg_rdata == {16'h0805, 7'h00, $past(dma_enable), sdcs_pkg::SILICON_REV_VAL})
    else $error("class code read wrong");
  a_status_fixed: assert property (cfg_req && !cfg_we && cfg_addr == 8'h04 |=>
    cfg_rdata[26:25] == 2'h1 && cfg_rdata[23:20] == 4'h1 && cfg_rdata[18:0] == 19'h0)
    else $error("fixed status bits wrong");
  a_lat_write: assert property (cfg_req && cfg_we && cfg_addr == 8'h0c && cfg_be[1:0] == 2'h3 |=>
    {latency_value, system_line_size} == $past(cfg_wdata[15:0]))
    else $error("latency register not written");
  a_lat_end: assert property (lat_end_request |-> lat_expired && xfer_active)
    else $error("burst end without expiry");
  a_lat_restart: assert property (frame_start |=> !lat_expired || latency_value == 8'h00)
    else $error("latency count not restarted at zero");
endmodule

bind sdcs_cfg_regs sdcs_cfg_regs_sva chk (
  .clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .cmd_int_disable(cmd_int_disable), .dma_enable(dma_enable), .int_cond(int_cond),
  .int_signal_en(int_signal_en), .intx_o(intx_o), .intx_oe(intx_oe),
  .devsel_timing(devsel_timing), .latency_value(latency_value),
  .system_line_size(system_line_size), .lat_expired(lat_expired),
  .lat_end_request(lat_end_request), .xfer_active(xfer_active), .frame_start(frame_start)
);

// >>> tb/sdcs_host_model.sv
// configuration host model issuing single cycles on the register port
`timescale 1ns/1ps
module sdcs_host_model (
  // clock
  input  wire logic  clk,
  // request side
  output logic       cfg_req,
  output logic       cfg_we,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  // answer side
  input  wire logic  cfg_ack
);
  // ********
  // access
  // ********
  initial begin
    {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = '0;
  end

  // one request pulse, then a bounded wait for the answer
  task automatic access(input logic we, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output bit ok);
    int n;
    @(posedge clk);
    cfg_req   <= 1'b1;
    cfg_we    <= we;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_req   <= 1'b0;
    // released lines flip so stale values never look valid
    {cfg_we, cfg_addr, cfg_be, cfg_wdata} <= ~{we, a, be, d};
    ok = 1'b0;
    // the answer is taken at the rising edge where it is seen high
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      ok = (cfg_ack === 1'b1);
    end
  endtask
endmodule

// >>> tb/sdcs_cfg_regs_tb_top.sv
// testbench for the configuration register block
`timescale 1ns/1ps
module sdcs_cfg_regs_tb_top;
  // ********
  // signals
  // ********
  logic        clk, rst, cmd_int_disable, parity_resp_en, dma_enable, perr_n_pin;
  logic        gnt_n_pin, master_data_phase, frame_start, xfer_active, pclk_tick;
  logic [4:0]  err_event;
  logic [3:0]  int_cond, int_signal_en;
  logic        cfg_req, cfg_we, cfg_ack, intx_o, intx_oe, lat_expired, lat_end_request;
  logic [7:0]  cfg_addr, latency_value, system_line_size;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, v;
  logic [1:0]  devsel_timing;
  logic [31:0] exp_q[$];
  int          error_cnt, checks, seed;
  bit          ok;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  sdcs_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack));

  sdcs_cfg_regs uut (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .cmd_int_disable(cmd_int_disable),
    .parity_error_response_enable(parity_resp_en), .dma_enable(dma_enable),
    .perr_n_pin(perr_n_pin), .gnt_n_pin(gnt_n_pin), .master_data_phase(master_data_phase),
    .frame_start(frame_start), .xfer_active(xfer_active), .pclk_tick(pclk_tick),
    .lat_expired(lat_expired), .lat_end_request(lat_end_request), .err_event(err_event),
    .int_cond(int_cond), .int_signal_en(int_signal_en), .intx_o(intx_o), .intx_oe(intx_oe),
    .devsel_timing(devsel_timing), .latency_value(latency_value),
    .system_line_size(system_line_size));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // note the expected answer first; a missing answer ends the run
  task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] exp);
    exp_q.push_back(exp);
    host.access(we, a, be, d, ok);
    if (!ok) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // answers are matched in order against the notes
  always @(negedge clk) begin
    if (cfg_ack === 1'b1) begin
      cmp(cfg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    seed = 34;
    error_cnt = 0;
    checks = 0;
    rst = 1'b1;
    {cmd_int_disable, parity_resp_en, dma_enable, gnt_n_pin, master_data_phase} = '0;
    {frame_start, xfer_active, pclk_tick, err_event, int_cond, int_signal_en} = '0;
    perr_n_pin = 1'b1;
    cyc(5);
    rst <= 1'b0;
    // reset values, fixed fields, ignored writes, unmapped place
    acc(0, 8'h0c, 4'hf, 32'h0, 32'h0);
    acc(0, 8'h04, 4'hf, 32'h0, 32'h0210_0000);
    acc(1, 8'h08, 4'hf, 32'hffff_ffff, 32'h0);
    acc(1, 8'h04, 4'hf, 32'hffff_ffff, 32'h0);
    acc(0, 8'h04, 4'hf, 32'h0, 32'h0210_0000);
    acc(0, 8'h20, 4'hf, 32'h0, 32'h0);
    cmp({30'h0, devsel_timing}, {30'h0, sdcs_pkg::DEVSEL_MEDIUM});
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) dma_enable <= i[0];
      acc(0, 8'h08, 4'hf, 32'h0, {16'h0805, 7'h0, i[0], sdcs_pkg::SILICON_REV_VAL});
    end
    $display("test fixed fields done");
    // latency and line size, whole and by byte lane
    v = $random(seed);
    acc(1, 8'h0c, 4'h3, v, 32'h0);
    acc(1, 8'h0c, 4'h1, ~v, 32'h0);
    acc(0, 8'h0c, 4'hf, 32'h0, {16'h0, v[15:8], ~v[7:0]});
    cmp({16'h0, latency_value, system_line_size}, {16'h0, v[15:8], ~v[7:0]});
    $display("test latency register done");
    // parity flag needs both mastership and the response enable
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {parity_resp_en, master_data_phase} <= i[1:0];
      perr_n_pin <= 1'b0;
      cyc(4);
      perr_n_pin <= 1'b1;
      master_data_phase <= 1'b0;
      cyc(4);
      acc(1, 8'h04, 4'hc, 32'h0, 32'h0);
      acc(0, 8'h04, 4'hf, 32'h0, {7'h01, i == 3, 8'h10, 16'h0});
      acc(1, 8'h04, 4'hc, 32'h0100_0000, 32'h0);
      acc(0, 8'h04, 4'hf, 32'h0, 32'h0210_0000);
    end
    // random error flags, cleared by writing ones
    v = $random(seed);
    @(posedge clk) err_event <= v[4:0];
    @(posedge clk) err_event <= 5'h0;
    cyc(2);
    acc(0, 8'h04, 4'hf, 32'h0, {v[4:0], 11'h210, 16'h0});
    acc(1, 8'h04, 4'hc, 32'hf800_0000, 32'h0);
    acc(0, 8'h04, 4'hf, 32'h0, 32'h0210_0000);
    $display("test status flags done");
    // each source: pending only if enabled, pin masked by the disable bit
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) int_cond <= 4'h1 << i;
      cyc(2);
      @(negedge clk);
      cmp({31'h0, intx_oe}, 32'h0);
      acc(0, 8'h04, 4'hf, 32'h0, 32'h0210_0000);
      @(posedge clk) int_signal_en <= 4'h1 << i;
      cyc(2);
      @(negedge clk);
      cmp({30'h0, intx_o, intx_oe}, 32'h1);
      @(posedge clk) cmd_int_disable <= 1'b1;
      @(negedge clk);
      cmp({30'h0, intx_o, intx_oe}, 32'h0);
      acc(0, 8'h04, 4'hf, 32'h0, 32'h0218_0000);
      @(posedge clk) {cmd_int_disable, int_cond, int_signal_en} <= 9'h0;
    end
    $display("test interrupt done");
    // latency count of four, burst end only once grant is removed
    acc(1, 8'h0c, 4'h2, 32'h0000_0400, 32'h0);
    @(posedge clk) {frame_start, xfer_active, pclk_tick} <= 3'h7;
    @(posedge clk) frame_start <= 1'b0;
    @(negedge clk);
    cmp({30'h0, lat_expired, lat_end_request}, 32'h0);
    cyc(6);
    @(negedge clk);
    cmp({30'h0, lat_expired, lat_end_request}, 32'h2);
    @(posedge clk) gnt_n_pin <= 1'b1;
    cyc(4);
    @(negedge clk);
    cmp({30'h0, lat_expired, lat_end_request}, 32'h3);
    @(posedge clk) {xfer_active, pclk_tick} <= 2'h0;
    $display("test latency timer done");
    cyc(2);
    wrap_up();
  end
endmodule
